// ==== pkg/hspm_pkg.sv ====
// Constants, register map and types of the host and serial pin multiplexer.
// Assumes a 20 MHz core clock and an APB master with 32-bit data.
// Notes on behaviour
// - Non-multiplexed host mode: pins give address 0-2
// - Multiplexed host mode: strobe and address 8-10
// - Address strobe polarity programmable, active-low at reset
// - Chip select polarity programmable, active-low at reset
// - Host GPIO pins: direction per bit register
// - Serial pins reset to general-purpose inputs
// - Serial GPIO pins: direction per bit register
// - Frame sync: both sides synchronous, transmitter asynchronous
// - Frame sync output driven internally, input taken
// - Bit clock: both sides synchronous, transmitter asynchronous
// - Receive pin shifts in, transmit pin shifts out
// - Stop: pin inputs ignored, outputs tri-stated; rxAltClk and rxAltFs still reach the receiver
package hspm_pkg;
  localparam int ADDR_W = 8;
  localparam int PIN_N = 4;
  localparam int WORD_W = 8;
  localparam int CNT_W = 4;
  localparam int DIV_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_HOST_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_HOST_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_HOST_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SER_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_SER_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SER_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SER_CLKDIV = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SER_TXDATA = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_SER_RXDATA = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  // Host control fields
  localparam int HC_FUNC_EN = 0;
  localparam int HC_MUX_BUS = 1;
  localparam int HC_STRB_HIGH = 2;
  localparam int HC_CS_HIGH = 3;
  // Serial control fields; bits 3:0 select the serial function per pin
  localparam int SC_SYNC = 4;
  localparam int SC_FS_OUT = 5;
  localparam int SC_CLK_OUT = 6;
  // Serial pin order
  localparam int SP_FS = 0;
  localparam int SP_CLK = 1;
  localparam int SP_RX = 2;
  localparam int SP_TX = 3;
  // Status fields
  localparam int ST_RX_FULL = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_STOP = 2;
  localparam int ST_ADDR_LO = 4;
  localparam int ST_ADDR_HI = 8;
  localparam int ST_STRB = 11;
  localparam int ST_CS = 12;
  // Reset values
  localparam logic [3:0] HOST_CTRL_RST = 4'h0;
  localparam logic [6:0] SER_CTRL_RST = 7'h00;
  localparam logic [PIN_N-1:0] DIR_RST = 4'h0;
  localparam logic [PIN_N-1:0] DATA_RST = 4'h0;
  localparam logic [DIV_W-1:0] CLKDIV_RST = 8'h03;
  // External bit clock period in core cycles, and least half period
  localparam int EXT_CLK_MIN_PERIOD_T = 6;
  localparam logic [DIV_W-1:0] MIN_HALF_CYC = DIV_W'(EXT_CLK_MIN_PERIOD_T / 2);
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} hspm_tx_t;
endpackage

// ==== pkg/hspm_if.sv ====
// Carriers between the pin multiplexer and its host decoder and shifter.
// Assumes the top drives pin levels and configuration, the leaves the rest.
interface hspm_host_if;
  import hspm_pkg::*;
  logic [PIN_N-1:0] pinLevel;
  logic muxBus;
  logic strobeHigh;
  logic csHigh;
  logic [2:0] addrLo;
  logic [2:0] addrHi;
  logic strobe;
  logic chipSel;
  modport cfg (output pinLevel, muxBus, strobeHigh, csHigh,
    input addrLo, addrHi, strobe, chipSel);
  modport dec (input pinLevel, muxBus, strobeHigh, csHigh,
    output addrLo, addrHi, strobe, chipSel);
endinterface

interface hspm_ser_if;
  import hspm_pkg::*;
  logic txClk, txFs, rxClk, rxFs, rxBit, fsIsOut, txLoad;
  logic [WORD_W-1:0] txWord;
  logic txBit, txActive, txBusy, fsGen, rxDone;
  logic [WORD_W-1:0] rxWord;
  modport cfg (output txClk, txFs, rxClk, rxFs, rxBit, fsIsOut, txLoad, txWord,
    input txBit, txActive, txBusy, fsGen, rxDone, rxWord);
  modport shift (input txClk, txFs, rxClk, rxFs, rxBit, fsIsOut, txLoad, txWord,
    output txBit, txActive, txBusy, fsGen, rxDone, rxWord);
endinterface

// ==== src/hspm_host_dec.sv ====
// Host pin decoder: turns sampled host pin levels into host bus signals.
// Assumes the levels are already registered and held during stop.
module hspm_host_dec
  import hspm_pkg::*;
(
  hspm_host_if.dec host // Pin levels in, decoded signals out
);
  // Polarity applied before use so the host port sees active-high
  always_comb
  begin
    host.addrLo = 3'h0;
    host.addrHi = 3'h0;
    host.strobe = 1'b0;
    host.chipSel = 1'b0;
    if (host.muxBus)
    begin
      host.strobe = host.pinLevel[0] ~^ host.strobeHigh;
      host.addrHi = host.pinLevel[3:1];
    end
    else
    begin
      host.addrLo = host.pinLevel[2:0];
      host.chipSel = host.pinLevel[3] ~^ host.csHigh;
    end
  end
endmodule // hspm_host_dec

// ==== src/hspm_shifter.sv ====
// Serial shifter: receive and transmit shift registers on the bit clock.
// Assumes clock and frame levels are sampled on the core clock.
module hspm_shifter
  import hspm_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic srst, // Synchronous reset
  hspm_ser_if.shift ser // Levels in, words and pin data out
);
  logic txClkPrev_ff;
  logic rxClkPrev_ff;
  logic txFall;
  logic rxRise;
  hspm_tx_t txState_ff;
  logic [WORD_W-1:0] txShift_ff;
  logic [CNT_W-1:0] txCnt_ff;
  logic [WORD_W-1:0] rxShift_ff;
  logic [CNT_W-1:0] rxCnt_ff;
  logic rxBusy_ff;
  logic rxDone_ff;
  logic [WORD_W-1:0] rxWord_ff;

  // Edge detect; a half period of three cycles keeps edges visible
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txClkPrev_ff <= 1'b0;
      rxClkPrev_ff <= 1'b0;
    end
    else
    begin
      txClkPrev_ff <= ser.txClk;
      rxClkPrev_ff <= ser.rxClk;
    end
  end
  assign txFall = txClkPrev_ff & ~ser.txClk;
  assign rxRise = ser.rxClk & ~rxClkPrev_ff;

  // Transmitter: data changes on falling bit clock edges
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txState_ff <= TX_IDLE;
      txShift_ff <= '0;
      txCnt_ff <= '0;
    end
    else
    begin
      unique case (txState_ff)
        TX_IDLE:
          if (ser.txLoad)
          begin
            txShift_ff <= ser.txWord;
            txState_ff <= TX_WAIT;
          end
        TX_WAIT:
          if (txFall && (ser.fsIsOut || ser.txFs))
          begin
            txCnt_ff <= '0;
            txState_ff <= TX_SHIFT;
          end
        TX_SHIFT:
          if (txFall)
          begin
            if (txCnt_ff == CNT_W'(WORD_W - 1))
              txState_ff <= TX_IDLE;
            else
            begin
              txShift_ff <= {txShift_ff[WORD_W-2:0], 1'b0};
              txCnt_ff <= txCnt_ff + 1'b1;
            end
          end
      endcase
    end
  end
  assign ser.txActive = (txState_ff == TX_SHIFT);
  assign ser.txBusy = (txState_ff != TX_IDLE);
  assign ser.txBit = txShift_ff[WORD_W-1];
  // Internal frame sync marks the first bit of each word
  assign ser.fsGen = (txState_ff == TX_SHIFT) && (txCnt_ff == '0);

  // Receiver: samples on rising edges, word starts on frame sync
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxShift_ff <= '0;
      rxCnt_ff <= '0;
      rxBusy_ff <= 1'b0;
      rxDone_ff <= 1'b0;
      rxWord_ff <= '0;
    end
    else
    begin
      rxDone_ff <= 1'b0;
      if (rxRise && (rxBusy_ff || ser.rxFs))
      begin
        rxShift_ff <= {rxShift_ff[WORD_W-2:0], ser.rxBit};
        if (rxBusy_ff && rxCnt_ff == CNT_W'(WORD_W - 1))
        begin
          rxWord_ff <= {rxShift_ff[WORD_W-2:0], ser.rxBit};
          rxDone_ff <= 1'b1;
          rxBusy_ff <= 1'b0;
        end
        else
        begin
          rxBusy_ff <= 1'b1;
          rxCnt_ff <= rxBusy_ff ? rxCnt_ff + 1'b1 : CNT_W'(1);
        end
      end
    end
  end
  assign ser.rxDone = rxDone_ff;
  assign ser.rxWord = rxWord_ff;
endmodule // hspm_shifter

// ==== src/hspm_top.sv ====
// Host and serial pin multiplexer with an APB register slave.
// Assumes pin inputs synchronous to clk and one pad cell per pin outside.
//
// Added by the designer: the placing of the registers and the APB slave port.
module hspm_top
  import hspm_pkg::*;
(
  input wire logic clk, // Core clock, 20 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic stopReq, // Core in stop state
  input wire logic rxAltClk, // Receiver clock for asynchronous mode
  input wire logic rxAltFs, // Receiver frame sync for asynchronous mode
  input wire logic [PIN_N-1:0] hostPinIn, // Host pin levels
  output logic [PIN_N-1:0] hostPinOut, // Host pin drive values
  output logic [PIN_N-1:0] hostPinOe, // Host pin enables
  input wire logic [PIN_N-1:0] serPinIn, // Serial pin levels
  output logic [PIN_N-1:0] serPinOut, // Serial pin drive values
  output logic [PIN_N-1:0] serPinOe, // Serial pin enables
  output logic [2:0] hostAddrLo, // Host address 2:0
  output logic [2:0] hostAddrHi, // Host address 10:8
  output logic hostStrobe, // Address strobe, active high
  output logic hostChipSel // Chip select, active high
);
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [3:0] hostCtrl_ff;
  logic [PIN_N-1:0] hostDir_ff;
  logic [PIN_N-1:0] hostData_ff;
  logic [6:0] serCtrl_ff;
  logic [PIN_N-1:0] serDir_ff;
  logic [PIN_N-1:0] serData_ff;
  logic [DIV_W-1:0] clkDiv_ff;
  logic [WORD_W-1:0] txWord_ff;
  logic txLoad_ff;
  logic rxFull_ff;
  logic [PIN_N-1:0] hostIn_ff;
  logic [PIN_N-1:0] serIn_ff;
  logic [DIV_W-1:0] divCnt_ff;
  logic genClk_ff;
  logic [PIN_N-1:0] hostPinOut_ff;
  logic [PIN_N-1:0] hostPinOe_ff;
  logic [PIN_N-1:0] serPinOut_ff;
  logic [PIN_N-1:0] serPinOe_ff;
  logic [2:0] hostAddrLo_ff;
  logic [2:0] hostAddrHi_ff;
  logic hostStrobe_ff;
  logic hostChipSel_ff;
  logic apbSetup;
  logic wrEn;
  logic rdEn;
  logic [PIN_N-1:0] serFunc;
  logic [PIN_N-1:0] serFnOut;
  logic [PIN_N-1:0] serFnOe;
  logic [DIV_W-1:0] halfCyc;
  logic clkGenOn;
  logic txClkPin;
  logic fsPin;

  hspm_host_if host ();
  hspm_ser_if ser ();

  // True when an access addresses the given register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Read view of every register; zero above the used bits
  function automatic logic [31:0] readWord(input logic [ADDR_W-1:0] a);
    readWord = 32'h0000_0000;
    if (hit(a, OFF_HOST_CTRL)) readWord[3:0] = hostCtrl_ff;
    if (hit(a, OFF_HOST_DIR)) readWord[PIN_N-1:0] = hostDir_ff;
    if (hit(a, OFF_HOST_DATA)) readWord[PIN_N-1:0] = hostIn_ff;
    if (hit(a, OFF_SER_CTRL)) readWord[6:0] = serCtrl_ff;
    if (hit(a, OFF_SER_DIR)) readWord[PIN_N-1:0] = serDir_ff;
    if (hit(a, OFF_SER_DATA)) readWord[PIN_N-1:0] = serIn_ff;
    if (hit(a, OFF_SER_CLKDIV)) readWord[DIV_W-1:0] = clkDiv_ff;
    if (hit(a, OFF_SER_TXDATA)) readWord[WORD_W-1:0] = txWord_ff;
    if (hit(a, OFF_SER_RXDATA)) readWord[WORD_W-1:0] = ser.rxWord;
    if (hit(a, OFF_STATUS))
    begin
      readWord[ST_RX_FULL] = rxFull_ff;
      readWord[ST_TX_BUSY] = ser.txBusy;
      readWord[ST_STOP] = stopReq;
      readWord[ST_ADDR_LO +: 3] = hostAddrLo_ff;
      readWord[ST_ADDR_HI +: 3] = hostAddrHi_ff;
      readWord[ST_STRB] = hostStrobe_ff;
      readWord[ST_CS] = hostChipSel_ff;
    end
  endfunction

  // Any printed register offset
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_HOST_CTRL) | hit(a, OFF_HOST_DIR) | hit(a, OFF_HOST_DATA) |
      hit(a, OFF_SER_CTRL) | hit(a, OFF_SER_DIR) | hit(a, OFF_SER_DATA) |
      hit(a, OFF_SER_CLKDIV) | hit(a, OFF_SER_TXDATA) | hit(a, OFF_SER_RXDATA) |
      hit(a, OFF_STATUS);
  endfunction

  // One wait state: data and error settle with ready
  assign apbSetup = psel & penable & ~pready_ff;
  assign wrEn = psel & penable & pready_ff & pwrite;
  assign rdEn = psel & penable & pready_ff & ~pwrite;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= apbSetup;
      pslverr_ff <= apbSetup & ~mapped(paddr);
      if (apbSetup && !pwrite)
        prdata_ff <= readWord(paddr);
    end
  end

  // Host configuration; polarity bits clear means active low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hostCtrl_ff <= HOST_CTRL_RST;
      hostDir_ff <= DIR_RST;
      hostData_ff <= DATA_RST;
    end
    else if (wrEn)
    begin
      if (hit(paddr, OFF_HOST_CTRL)) hostCtrl_ff <= pwdata[3:0];
      if (hit(paddr, OFF_HOST_DIR)) hostDir_ff <= pwdata[PIN_N-1:0];
      if (hit(paddr, OFF_HOST_DATA)) hostData_ff <= pwdata[PIN_N-1:0];
    end
  end

  // Serial configuration; reset leaves every pin a GPIO input
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      serCtrl_ff <= SER_CTRL_RST;
      serDir_ff <= DIR_RST;
      serData_ff <= DATA_RST;
      clkDiv_ff <= CLKDIV_RST;
    end
    else if (wrEn)
    begin
      if (hit(paddr, OFF_SER_CTRL)) serCtrl_ff <= pwdata[6:0];
      if (hit(paddr, OFF_SER_DIR)) serDir_ff <= pwdata[PIN_N-1:0];
      if (hit(paddr, OFF_SER_DATA)) serData_ff <= pwdata[PIN_N-1:0];
      if (hit(paddr, OFF_SER_CLKDIV)) clkDiv_ff <= pwdata[DIV_W-1:0];
    end
  end

  // Transmit word; a write while busy is dropped, not queued
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txWord_ff <= '0;
      txLoad_ff <= 1'b0;
    end
    else
    begin
      txLoad_ff <= 1'b0;
      if (wrEn && hit(paddr, OFF_SER_TXDATA) && !ser.txBusy && !txLoad_ff)
      begin
        txWord_ff <= pwdata[WORD_W-1:0];
        txLoad_ff <= 1'b1;
      end
    end
  end

  // Receive full flag; a new word wins over the clearing read
  always_ff @(posedge clk)
  begin
    if (srst)
      rxFull_ff <= 1'b0;
    else if (ser.rxDone)
      rxFull_ff <= 1'b1;
    else if (rdEn && hit(paddr, OFF_SER_RXDATA))
      rxFull_ff <= 1'b0;
  end

  // Pin sampling; frozen in stop so inputs are ignored
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hostIn_ff <= '0;
      serIn_ff <= '0;
    end
    else if (!stopReq)
    begin
      hostIn_ff <= hostPinIn;
      serIn_ff <= serPinIn;
    end
  end

  // Internal bit clock; half period never below the core minimum
  assign halfCyc = (clkDiv_ff < MIN_HALF_CYC) ? MIN_HALF_CYC : clkDiv_ff;
  assign clkGenOn = serFunc[SP_CLK] & serCtrl_ff[SC_CLK_OUT] & ~stopReq;

  always_ff @(posedge clk)
  begin
    if (srst || !clkGenOn)
    begin
      divCnt_ff <= '0;
      genClk_ff <= 1'b0;
    end
    else if (divCnt_ff >= halfCyc - 1'b1)
    begin
      divCnt_ff <= '0;
      genClk_ff <= ~genClk_ff;
    end
    else
      divCnt_ff <= divCnt_ff + 1'b1;
  end

  // Serial clock and frame routing between pins and shifter
  assign serFunc = serCtrl_ff[PIN_N-1:0];
  assign fsPin = serFunc[SP_FS] & serIn_ff[SP_FS];
  assign txClkPin = serCtrl_ff[SC_CLK_OUT] ? genClk_ff
    : (serFunc[SP_CLK] & serIn_ff[SP_CLK]);
  assign ser.txClk = txClkPin;
  assign ser.txFs = fsPin;
  assign ser.fsIsOut = serCtrl_ff[SC_FS_OUT];
  assign ser.rxClk = serCtrl_ff[SC_SYNC] ? txClkPin : rxAltClk;
  assign ser.rxFs = serCtrl_ff[SC_SYNC]
    ? (serCtrl_ff[SC_FS_OUT] ? ser.fsGen : fsPin) : rxAltFs;
  assign ser.rxBit = serFunc[SP_RX] & serIn_ff[SP_RX];
  assign ser.txLoad = txLoad_ff;
  assign ser.txWord = txWord_ff;

  hspm_shifter u_shifter (
    .clk (clk),
    .srst (srst),
    .ser (ser)
  );

  // Serial function drive per pin
  assign serFnOut[SP_FS] = ser.fsGen;
  assign serFnOe[SP_FS] = serCtrl_ff[SC_FS_OUT];
  assign serFnOut[SP_CLK] = genClk_ff;
  assign serFnOe[SP_CLK] = serCtrl_ff[SC_CLK_OUT];
  assign serFnOut[SP_RX] = 1'b0;
  assign serFnOe[SP_RX] = 1'b0;
  assign serFnOut[SP_TX] = ser.txBit;
  assign serFnOe[SP_TX] = ser.txActive;

  // Pad registers; stop tri-states every pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          hostPinOut_ff[gi] <= 1'b0;
          hostPinOe_ff[gi] <= 1'b0;
          serPinOut_ff[gi] <= 1'b0;
          serPinOe_ff[gi] <= 1'b0;
        end
        else
        begin
          // Host function pins are inputs only and ignore data
          hostPinOut_ff[gi] <= hostCtrl_ff[HC_FUNC_EN] ? 1'b0 : hostData_ff[gi];
          hostPinOe_ff[gi] <= ~stopReq & ~hostCtrl_ff[HC_FUNC_EN] & hostDir_ff[gi];
          serPinOut_ff[gi] <= serFunc[gi] ? serFnOut[gi] : serData_ff[gi];
          serPinOe_ff[gi] <= ~stopReq & (serFunc[gi] ? serFnOe[gi] : serDir_ff[gi]);
        end
      end
    end
  endgenerate

  // Host decoder always sees the pins; its outputs are registered only when the host function owns them
  assign host.pinLevel = hostIn_ff;
  assign host.muxBus = hostCtrl_ff[HC_MUX_BUS];
  assign host.strobeHigh = hostCtrl_ff[HC_STRB_HIGH];
  assign host.csHigh = hostCtrl_ff[HC_CS_HIGH];

  hspm_host_dec u_host_dec (
    .host (host)
  );

  always_ff @(posedge clk)
  begin
    if (srst || !hostCtrl_ff[HC_FUNC_EN])
    begin
      hostAddrLo_ff <= 3'h0;
      hostAddrHi_ff <= 3'h0;
      hostStrobe_ff <= 1'b0;
      hostChipSel_ff <= 1'b0;
    end
    else
    begin
      hostAddrLo_ff <= host.addrLo;
      hostAddrHi_ff <= host.addrHi;
      hostStrobe_ff <= host.strobe;
      hostChipSel_ff <= host.chipSel;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign hostPinOut = hostPinOut_ff;
  assign hostPinOe = hostPinOe_ff;
  assign serPinOut = serPinOut_ff;
  assign serPinOe = serPinOe_ff;
  assign hostAddrLo = hostAddrLo_ff;
  assign hostAddrHi = hostAddrHi_ff;
  assign hostStrobe = hostStrobe_ff;
  assign hostChipSel = hostChipSel_ff;
endmodule // hspm_top

// ==== dv/hspm_asserts.sv ====
// Checker of APB handshake, reset, stop and host decode of hspm_top.
// Assumes it is bound to hspm_top and sees its ports only.
module hspm_asserts
(
  input wire logic clk, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic stopReq, // Stop state
  input wire logic [3:0] hostPinOe, // Host enables
  input wire logic [3:0] serPinOe, // Serial enables
  input wire logic [2:0] hostAddrLo, // Address 2:0
  input wire logic [2:0] hostAddrHi, // Address 10:8
  input wire logic hostStrobe, // Strobe
  input wire logic hostChipSel // Chip select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // One wait state, then a one-cycle answer
  apb_wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  apb_ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  apb_ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  apb_error_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("pslverr misplaced or read data not zero");
  // Drivers come up released and drop one cycle into stop
  reset_released_a:
    assert property ($past(srst) |-> hostPinOe == 4'h0 && serPinOe == 4'h0)
    else $error("pins driven after reset");
  stop_tristate_a:
    assert property (stopReq |=> hostPinOe == 4'h0 && serPinOe == 4'h0)
    else $error("pins still driven in stop");
  // Samples frozen so a moving pin cannot leak through
  stop_input_hold_a:
    assert property (stopReq [*3] |=> $stable({hostAddrLo, hostAddrHi, hostStrobe, hostChipSel}))
    else $error("host decode moved in stop");
  mode_exclusive_a: assert property (!(hostStrobe && hostChipSel))
    else $error("strobe and chip select both active");
  // Host enables move only after a write, a stop edge or a reset
  host_oe_cause_a:
    assert property ($changed(hostPinOe) |-> ($past(pready) && $past(pwrite))
      || ($past(pready, 2) && $past(pwrite, 2)) || $past(stopReq) || $past(stopReq, 2)
      || $past(srst))
    else $error("host enable changed without cause");
endmodule // hspm_asserts

bind hspm_top hspm_asserts asserts_u (.clk, .srst, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .stopReq, .hostPinOe, .serPinOe, .hostAddrLo, .hostAddrHi, .hostStrobe,
  .hostChipSel);

// ==== dv/hspm_serial_peer.sv ====
// Serial peripheral on the far side of the serial pins, with pad resolution.
// Assumes the core clock; its own bit clock runs only inside a frame.
module hspm_serial_peer
  import hspm_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic go, // Start one frame
  input wire logic [WORD_W-1:0] word, // Word sent to the receiver
  input wire logic [PIN_N-1:0] pinOut, // Device drive values
  input wire logic [PIN_N-1:0] pinOe, // Device enables
  output logic [PIN_N-1:0] pinIn, // Resolved pin levels
  output logic [WORD_W-1:0] gotWord // Last bits seen on the transmit pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt = '0;
  logic busy = 1'b0;
  logic tgl = 1'b0;
  logic clkLast = 1'b0;
  logic [2:0] idx;
  assign idx = 3'(cnt / 6);

  // Eight bits of six core cycles: half period 3, the least allowed
  always @(posedge clk)
  begin
    tgl <= !tgl;
    clkLast <= pinIn[SP_CLK];
    if (go)
      busy <= 1'b1;
    else if (cnt == 6'd47)
      busy <= 1'b0;
    cnt <= (busy && cnt != 6'd47) ? cnt + 6'd1 : 6'd0;
    if (pinIn[SP_CLK] && !clkLast && pinOe[SP_TX])
      gotWord <= {gotWord[WORD_W-2:0], pinOut[SP_TX]};
  end

  // Released clock and frame rest low; data lines toggle so no stale bit passes
  always_comb
  begin
    pinIn[SP_FS] = pinOe[SP_FS] ? pinOut[SP_FS] : busy && idx == 3'd0;
    pinIn[SP_CLK] = pinOe[SP_CLK] ? pinOut[SP_CLK] : busy && cnt % 6 >= 3;
    pinIn[SP_TX] = pinOe[SP_TX] ? pinOut[SP_TX] : tgl;
    pinIn[SP_RX] = pinOe[SP_RX] ? pinOut[SP_RX] : busy ? word[3'd7 - idx]
      : pinOe[SP_TX] ? pinOut[SP_TX] : tgl; // Loopback outside own frames
  end
endmodule // hspm_serial_peer

// ==== dv/test_host_and_serial_port_pin_mux.sv ====
// Self-checking bench of the host and serial pin multiplexer, random data.
// Assumes hspm_top, the serial peer model and the bound checker.
module test_host_and_serial_port_pin_mux
  import hspm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stopReq = 1'b0, go = 1'b0;
  logic rxAltClk = 1'b0, rxAltFs = 1'b0, pready, pslverr, errSeen, hostStrobe, hostChipSel;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic [PIN_N-1:0] hostDrv = '0, hostPinIn, hostPinOut, hostPinOe, serPinIn, serPinOut, serPinOe;
  logic [2:0] hostAddrLo, hostAddrHi;
  logic [WORD_W-1:0] word = '0, gotWord;
  int miscompares = 0, testsRun = 0;

  // Host processor drives every line the device leaves released
  assign hostPinIn = (hostPinOe & hostPinOut) | (~hostPinOe & hostDrv);
  hspm_top dut_u (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stopReq, .rxAltClk, .rxAltFs, .hostPinIn, .hostPinOut, .hostPinOe, .serPinIn,
    .serPinOut, .serPinOe, .hostAddrLo, .hostAddrHi, .hostStrobe, .hostChipSel);
  hspm_serial_peer peer_u (.clk, .go, .word, .pinOut(serPinOut), .pinOe(serPinOe),
    .pinIn(serPinIn), .gotWord);

  initial
    forever #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; only the watchdog ends a dead wait, idle cycle after
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdv, exp);
  endtask

  function automatic logic act(input logic lvl, input logic hiAct);
    return hiAct ? lvl : !lvl;
  endfunction

  // Sends a word; the peer loops it back to the receive pin
  task automatic serTx(input logic [6:0] ctrl, input logic rxOn);
    logic [WORD_W-1:0] w;
    int n;
    w = WORD_W'($urandom);
    n = 0;
    apb(1'b1, OFF_SER_CTRL, {25'h0, ctrl});
    apb(1'b1, OFF_SER_TXDATA, {24'h0, w});
    repeat (4) @(posedge clk);
    chk("fsOe", serPinOe[SP_FS], ctrl[SC_FS_OUT]);
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    while (rdv[ST_TX_BUSY] && n < 60);
    repeat (8) @(posedge clk);
    chk("txWord", gotWord, w);
    chk("txOe", serPinOe[SP_TX], 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("rxFull", rdv[ST_RX_FULL], rxOn);
    if (rxOn)
      rdchk(OFF_SER_RXDATA, w, "rxWord");
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial
  begin
    logic [3:0] d, v;
    void'($urandom(96));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(OFF_HOST_CTRL, 32'h0, "hostCtrl");
    rdchk(OFF_SER_CTRL, 32'h0, "serCtrl");
    rdchk(OFF_SER_CLKDIV, 32'h3, "clkDiv");
    chk("serOe", serPinOe, 4'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("slvErr", errSeen, 1'b1);
    // Host pins as general-purpose I/O, direction per bit
    repeat (4)
    begin
      d = 4'($urandom);
      v = 4'($urandom);
      hostDrv <= 4'($urandom);
      apb(1'b1, OFF_HOST_DIR, {28'h0, d});
      apb(1'b1, OFF_HOST_DATA, {28'h0, v});
      repeat (3) @(posedge clk);
      chk("hostOe", hostPinOe, d);
      chk("hostOut", hostPinOut & d, v & d);
      rdchk(OFF_HOST_DATA, (v & d) | (hostDrv & ~d), "hostPins");
    end
    d = 4'($urandom) | 4'h1;
    v = 4'($urandom);
    apb(1'b1, OFF_SER_DIR, {28'h0, d});
    apb(1'b1, OFF_SER_DATA, {28'h0, v});
    repeat (3) @(posedge clk);
    chk("serOe", serPinOe, d);
    chk("serOut", serPinOut & d, v & d);
    // Every mode and polarity of the host function; data register ignored
    for (int c = 1; c < 16; c += 2)
    begin
      hostDrv <= 4'($urandom);
      apb(1'b1, OFF_HOST_CTRL, c);
      apb(1'b1, OFF_HOST_DATA, 32'hF);
      repeat (3) @(posedge clk);
      chk("hostOe", hostPinOe, 4'h0);
      chk("hostFnOut", hostPinOut, 4'h0);
      if (c[1])
      begin
        chk("addrHi", hostAddrHi, hostDrv[3:1]);
        chk("strobe", hostStrobe, act(hostDrv[0], c[2]));
      end
      else
      begin
        chk("addrLo", hostAddrLo, hostDrv[2:0]);
        chk("chipSel", hostChipSel, act(hostDrv[3], c[3]));
      end
    end
    // Stop: outputs released, moving inputs ignored
    v = hostDrv;
    stopReq <= 1'b1;
    hostDrv <= ~hostDrv;
    repeat (4) @(posedge clk);
    chk("stopOe", serPinOe, 4'h0);
    chk("stopHold", hostAddrHi, v[3:1]);
    stopReq <= 1'b0;
    repeat (3) @(posedge clk);
    serTx(7'h7F, 1'b1);
    serTx(7'h6F, 1'b0);
    // External clock and frame from the peer
    apb(1'b1, OFF_SER_CTRL, 32'h1F);
    word <= WORD_W'($urandom);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (60) @(posedge clk);
    rdchk(OFF_SER_RXDATA, word, "extRx");
    final_report();
  end
endmodule // test_host_and_serial_port_pin_mux
